// >>> logic/agc_pkg.sv
// Constants, types and tables of the gain loop control block.
// Assumes one 50 MHz clock and a byte-wide register port.
// Notes on behaviour
// - The 4-bit absolute threshold is a signed dB offset from the goal.
// - Threshold code 1000 turns absolute carrier sense off.
// - The threshold sits at goal plus code dB, from -7 to +7.
// - Bits 7:6 pick hysteresis and dead zone, medium after reset.
// - Hold code 00 lets the loop change gain whenever needed.
// - Hold code 01 freezes gain once a sync word is found.
// - Hold code 10 freezes analog gain, digital gain still moves.
// - Hold code 11 freezes both gains; software may set them.
// - Amplitude is averaged over 8/16/32/64 samples, 16 at reset.
// - The averaging code also sets the on-off keying decision margin.
// - Goal code picks 24..42 dB, 33 dB after reset.
package agc_pkg;

	localparam logic [15:0] GOAL_ADDR   = 16'hdf17;
	localparam logic [15:0] CS_ADDR     = 16'hdf18;
	localparam logic [15:0] LOOP_ADDR   = 16'hdf19;
	localparam logic [15:0] STATUS_ADDR = 16'hdf40;
	localparam logic [15:0] MANUAL_ADDR = 16'hdf41;
	localparam logic [15:0] AVG_ADDR    = 16'hdf42;

	localparam logic [7:0] LOOP_RST   = 8'h91;
	localparam logic [2:0] GOAL_RST   = 3'h3;
	localparam logic [3:0] CS_RST     = 4'h0;
	localparam logic [3:0] CS_OFF     = 4'h8;
	localparam logic [2:0] GAIN_MAX   = 3'h7;
	localparam logic [7:0] GAIN_STEP  = 8'h03;

	localparam int HYST_LSB   = 6;
	localparam int SETTLE_LSB = 4;
	localparam int HOLD_LSB   = 2;
	localparam int AVG_LSB    = 0;
	localparam int ANA_LSB    = 4;

	localparam logic [7:0] GOAL_DB [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21,
		8'h24, 8'h26, 8'h28, 8'h2a};
	localparam logic [5:0] SETTLE_LEN [4] = '{6'h08, 6'h10, 6'h18, 6'h20};
	localparam logic [2:0] AVG_SHIFT [4] = '{3'h3, 3'h4, 3'h5, 3'h6};
	localparam logic [7:0] DZ_LOW [4] = '{8'h01, 8'h02, 8'h04, 8'h06};
	localparam logic [7:0] DZ_HIGH [4] = '{8'h01, 8'h01, 8'h02, 8'h02};
	localparam logic [7:0] HYST_DB [4] = '{8'h00, 8'h01, 8'h02, 8'h03};
	localparam logic [7:0] ASK_BOUND [4] = '{8'h06, 8'h05, 8'h04, 8'h03};

	typedef enum logic [1:0] {
		HOLD_NONE   = 2'b00,
		HOLD_SYNC   = 2'b01,
		HOLD_ANALOG = 2'b10,
		HOLD_ALL    = 2'b11
	} hold_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] db;
	} sample_t;

	typedef struct packed {
		logic [2:0] analog;
		logic [2:0] digital;
	} gain_t;

endpackage

// >>> logic/agc_avg.sv
// Amplitude averager over a power-of-two window of samples.
// Assumes samples come from logic on the same clock.
`timescale 1ns/1ps
module agc_avg #(
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          start,
	input  wire logic [1:0]    len_code,
	input  wire logic          smp_valid,
	input  wire logic [DW-1:0] smp_db,
	output logic               done,
	output logic [DW-1:0]      avg_db
);
	localparam int SW = DW + 6;

	logic [SW-1:0] sum_q;
	logic [SW-1:0] sum_d;
	logic [6:0]    cnt_q;
	logic [2:0]    shift_q;
	logic          last;

	assign sum_d = sum_q + SW'(smp_db);
	assign last  = smp_valid && (cnt_q == 7'((7'h01 << shift_q) - 7'h01));

	// Window length latched here so a write never cuts a window short
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			shift_q <= agc_pkg::AVG_SHIFT[1];
		else if (start)
			shift_q <= agc_pkg::AVG_SHIFT[len_code];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sum_q <= '0;
			cnt_q <= '0;
		end
		else if (start || last)
		begin
			sum_q <= '0;
			cnt_q <= '0;
		end
		else if (smp_valid)
		begin
			sum_q <= sum_d;
			cnt_q <= cnt_q + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			done   <= 1'b0;
			avg_db <= '0;
		end
		else
		begin
			done <= last && !start;
			if (last && !start)
				avg_db <= DW'(sum_d >> shift_q);
		end
	end

	logic [7:0] seen_q;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			seen_q <= '0;
		else if (start || done)
			seen_q <= '0;
		else if (smp_valid)
			seen_q <= seen_q + 8'h01;
	end

	win_len_a: assert property (@(posedge clk) disable iff (!nrst)
		done |-> seen_q == 8'(8'h01 << shift_q))
		else $error("average window length wrong");

endmodule // agc_avg

// >>> logic/agc_gain_loop_control.sv
// Receive gain loop: register file, settle wait, averaging, gain steps,
// carrier sense and on-off keying slicer.
// Assumes samples, sync and restart pulses come from the same clock.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module agc_gain_loop_control (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire agc_pkg::bus_req_t bus,
	output logic [7:0]             rd_data,
	input  wire agc_pkg::sample_t  sample,
	input  wire logic              sync_found,
	input  wire logic              rx_start,
	output agc_pkg::gain_t         gain,
	output logic                   carrier_sense,
	output logic                   ask_bit
);
	typedef enum logic [1:0] {
		ST_ACCUM  = 2'b00,
		ST_ADJUST = 2'b01,
		ST_SETTLE = 2'b10
	} state_t;

	state_t         state_q;
	logic [7:0]     loop_q;
	logic [2:0]     goal_q;
	logic [3:0]     thr_q;
	agc_pkg::gain_t manual_q;
	logic           sync_hold_q;
	logic           last_up_q;
	logic [5:0]     settle_cnt_q;
	logic [5:0]     settle_len_q;

	logic           acc_start;
	logic           avg_done;
	logic [7:0]     avg_db;
	agc_pkg::gain_t gain_d;
	logic           changed;
	logic           raise;
	logic           lower;
	logic           frz_ana;
	logic           frz_dig;
	logic           cs_en;
	logic           cs_hit;
	logic           settle_end;
	logic           manual_wr;

	agc_pkg::hold_t hold;
	logic [1:0]     hyst;
	logic [1:0]     avg_code;
	logic [7:0]     goal_db;

	assign hold     = agc_pkg::hold_t'(loop_q[agc_pkg::HOLD_LSB +: 2]);
	assign hyst     = loop_q[agc_pkg::HYST_LSB +: 2];
	assign avg_code = loop_q[agc_pkg::AVG_LSB +: 2];
	assign goal_db  = agc_pkg::GOAL_DB[goal_q];

	assign manual_wr = bus.wr && bus.addr == agc_pkg::MANUAL_ADDR;

	// Register writes
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			loop_q   <= agc_pkg::LOOP_RST;
			goal_q   <= agc_pkg::GOAL_RST;
			thr_q    <= agc_pkg::CS_RST;
			manual_q <= '{agc_pkg::GAIN_MAX, agc_pkg::GAIN_MAX};
		end
		else if (bus.wr)
		begin
			unique case (bus.addr)
				agc_pkg::LOOP_ADDR: loop_q <= bus.wdata;
				agc_pkg::GOAL_ADDR: goal_q <= bus.wdata[2:0];
				agc_pkg::CS_ADDR: thr_q <= bus.wdata[3:0];
				agc_pkg::MANUAL_ADDR:
				begin
					manual_q.analog  <= bus.wdata[agc_pkg::ANA_LSB +: 3];
					manual_q.digital <= bus.wdata[2:0];
				end
				default: ;
			endcase
		end
	end

	// Register reads, one cycle later; unmapped reads as zero
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rd_data <= '0;
		else if (bus.rd)
		begin
			unique case (bus.addr)
				agc_pkg::LOOP_ADDR: rd_data <= loop_q;
				agc_pkg::GOAL_ADDR: rd_data <= {5'h00, goal_q};
				agc_pkg::CS_ADDR: rd_data <= {4'h0, thr_q};
				agc_pkg::MANUAL_ADDR:
					rd_data <= {1'b0, manual_q.analog, 1'b0, manual_q.digital};
				agc_pkg::STATUS_ADDR:
					rd_data <= {carrier_sense, gain.analog, sync_hold_q,
						gain.digital};
				agc_pkg::AVG_ADDR: rd_data <= avg_db;
				default: rd_data <= '0;
			endcase
		end
		else
			rd_data <= '0;
	end

	// Sync freeze flag; a sync in the restart cycle still wins
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			sync_hold_q <= 1'b0;
		else if (sync_found)
			sync_hold_q <= 1'b1;
		else if (rx_start)
			sync_hold_q <= 1'b0;
	end

	always_comb
	begin
		frz_ana = 1'b0;
		frz_dig = 1'b0;
		unique case (hold)
			agc_pkg::HOLD_NONE: ;
			agc_pkg::HOLD_SYNC:
			begin
				frz_ana = sync_hold_q;
				frz_dig = sync_hold_q;
			end
			agc_pkg::HOLD_ANALOG: frz_ana = 1'b1;
			agc_pkg::HOLD_ALL:
			begin
				frz_ana = 1'b1;
				frz_dig = 1'b1;
			end
		endcase
	end

	// Dead zone widens by the hysteresis only against the last step
	logic [9:0] lo_edge;
	logic [9:0] hi_edge;
	assign lo_edge = {2'b00, avg_db} + {2'b00, agc_pkg::DZ_LOW[hyst]}
		+ (last_up_q ? 10'h000 : {2'b00, agc_pkg::HYST_DB[hyst]});
	assign hi_edge = {2'b00, goal_db} + {2'b00, agc_pkg::DZ_HIGH[hyst]}
		+ (last_up_q ? {2'b00, agc_pkg::HYST_DB[hyst]} : 10'h000);
	assign raise = lo_edge < {2'b00, goal_db};
	assign lower = {2'b00, avg_db} > hi_edge;

	always_comb
	begin
		gain_d = gain;
		if (raise)
		begin
			if (!frz_ana && gain.analog != agc_pkg::GAIN_MAX)
				gain_d.analog = gain.analog + 3'h1;
			else if (!frz_dig && gain.digital != agc_pkg::GAIN_MAX)
				gain_d.digital = gain.digital + 3'h1;
		end
		else if (lower)
		begin
			if (!frz_ana && gain.analog != 3'h0)
				gain_d.analog = gain.analog - 3'h1;
			else if (!frz_dig && gain.digital != 3'h0)
				gain_d.digital = gain.digital - 3'h1;
		end
	end

	assign changed = gain_d != gain;

	// Gain registers; manual load only while fully held
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			gain      <= '{agc_pkg::GAIN_MAX, agc_pkg::GAIN_MAX};
			last_up_q <= 1'b1;
		end
		else if (manual_wr && hold == agc_pkg::HOLD_ALL)
			gain <= '{bus.wdata[agc_pkg::ANA_LSB +: 3], bus.wdata[2:0]};
		else if (state_q == ST_ADJUST && changed)
		begin
			gain      <= gain_d;
			last_up_q <= raise;
		end
	end

	// Carrier sense: add back what the loop has taken off
	logic [3:0]         red_steps;
	logic signed [10:0] eq_amp;
	logic signed [10:0] thr_db;
	assign red_steps = {1'b0, agc_pkg::GAIN_MAX - gain.analog}
		+ {1'b0, agc_pkg::GAIN_MAX - gain.digital};
	assign eq_amp = 11'({3'b000, avg_db})
		+ 11'({7'h00, red_steps} * {3'b000, agc_pkg::GAIN_STEP});
	assign thr_db = 11'({3'b000, goal_db})
		+ 11'(signed'({{7{thr_q[3]}}, thr_q}));
	assign cs_en  = thr_q != agc_pkg::CS_OFF;
	assign cs_hit = cs_en && eq_amp >= thr_db;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			carrier_sense <= 1'b0;
		else if (!cs_en)
			carrier_sense <= 1'b0;
		else if (state_q == ST_ADJUST)
			carrier_sense <= cs_hit;
	end

	// Slicer margin shrinks as the average gets longer and steadier
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ask_bit <= 1'b0;
		else if (sample.valid)
			ask_bit <= {1'b0, sample.db} + {1'b0, agc_pkg::ASK_BOUND[avg_code]}
				>= {1'b0, avg_db};
	end

	// Settle wait counts samples; length latched on entry
	assign settle_end = state_q == ST_SETTLE && sample.valid
		&& settle_cnt_q == settle_len_q - 6'h01;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			settle_cnt_q <= '0;
			settle_len_q <= agc_pkg::SETTLE_LEN[1];
		end
		else if (state_q == ST_ADJUST)
		begin
			settle_cnt_q <= '0;
			settle_len_q <=
				agc_pkg::SETTLE_LEN[loop_q[agc_pkg::SETTLE_LSB +: 2]];
		end
		else if (state_q == ST_SETTLE && sample.valid)
			settle_cnt_q <= settle_cnt_q + 6'h01;
	end

	assign acc_start = (state_q == ST_ADJUST && !changed) || settle_end;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state_q <= ST_ACCUM;
		else
		begin
			unique case (state_q)
				ST_ACCUM:
					if (avg_done)
						state_q <= ST_ADJUST;
				ST_ADJUST:
					state_q <= changed ? ST_SETTLE : ST_ACCUM;
				ST_SETTLE:
					if (settle_end)
						state_q <= ST_ACCUM;
				default:
					state_q <= ST_ACCUM;
			endcase
		end
	end

	agc_avg #(
		.DW (8)
	) u_avg (
		.clk       (clk),
		.nrst      (nrst),
		.start     (acc_start),
		.len_code  (avg_code),
		.smp_valid (sample.valid && state_q == ST_ACCUM),
		.smp_db    (sample.db),
		.done      (avg_done),
		.avg_db    (avg_db)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	cs_off_a: assert property (
		thr_q == agc_pkg::CS_OFF |=> !carrier_sense)
		else $error("carrier sense while disabled");

	cs_level_a: assert property (
		state_q == ST_ADJUST && cs_en && !bus.wr |=> carrier_sense == $past(cs_hit))
		else $error("carrier sense not following threshold");

	cs_zero_a: assert property (
		state_q == ST_ADJUST && thr_q == 4'h0 && avg_db == goal_db
		|=> carrier_sense)
		else $error("zero code not at goal");

	hold_all_a: assert property (
		hold == agc_pkg::HOLD_ALL && !manual_wr && !bus.wr |=> $stable(gain))
		else $error("gain moved while fully held");

	hold_ana_a: assert property (
		hold == agc_pkg::HOLD_ANALOG && !bus.wr |=> $stable(gain.analog))
		else $error("analog gain moved while held");

	sync_freeze_a: assert property (
		hold == agc_pkg::HOLD_SYNC && sync_hold_q && !bus.wr |=> $stable(gain))
		else $error("gain moved after sync");

	free_step_a: assert property (
		state_q == ST_ADJUST && hold == agc_pkg::HOLD_NONE && raise
		&& gain.analog != agc_pkg::GAIN_MAX && !bus.wr
		|=> gain.analog == $past(gain.analog) + 3'h1)
		else $error("free loop did not raise gain");

	settle_wait_a: assert property (
		state_q == ST_ADJUST && changed ##1 state_q == ST_SETTLE
		|-> settle_len_q == agc_pkg::SETTLE_LEN[$past(loop_q[5:4])])
		else $error("settle length not latched");

	readback_a: assert property (
		bus.wr && bus.addr == agc_pkg::LOOP_ADDR ##1
		bus.rd && bus.addr == agc_pkg::LOOP_ADDR && !bus.wr
		|=> rd_data == $past(bus.wdata, 2))
		else $error("readback mismatch");

	sync_set_a: assert property (
		sync_found |=> sync_hold_q)
		else $error("sync flag not set");

	manual_load_a: assert property (
		manual_wr && hold == agc_pkg::HOLD_ALL
		|=> gain.analog == $past(bus.wdata[6:4])
		&& gain.digital == $past(bus.wdata[2:0]))
		else $error("manual gain not loaded");

	dig_step_a: assert property (
		state_q == ST_ADJUST && hold == agc_pkg::HOLD_ANALOG && lower
		&& gain.digital != 3'h0 && !bus.wr
		|=> gain.digital == $past(gain.digital) - 3'h1)
		else $error("digital gain did not step");

	settle_count_a: assert property (
		state_q == ST_SETTLE |-> settle_cnt_q < settle_len_q)
		else $error("settle count past its length");

	cs_rise_c: cover property ($rose(carrier_sense));
	settle_c: cover property (state_q == ST_SETTLE ##1 state_q == ST_ACCUM);
	sync_frz_c: cover property (hold == agc_pkg::HOLD_SYNC && $rose(sync_hold_q));
	raise_c: cover property (state_q == ST_ADJUST && raise && changed);

endmodule // agc_gain_loop_control

// >>> verification/agc_gain_loop_control_tb.sv
// Self-checking bench for the receive gain loop control block.
// Assumes the block's package is compiled first; the bench drives all ports.
`timescale 1ns/1ps
module agc_gain_loop_control_tb;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  exp;
	} row_t;

	localparam row_t ROWS [9] = '{
		'{16'hdf19, 8'h00, 8'h00}, '{16'hdf19, 8'hee, 8'hee},
		'{16'hdf19, 8'h91, 8'h91}, '{16'hdf17, 8'hff, 8'h07},
		'{16'hdf17, 8'h03, 8'h03}, '{16'hdf18, 8'hf7, 8'h07},
		'{16'hdf18, 8'h00, 8'h00}, '{16'hdf20, 8'h5a, 8'h00},
		'{16'hdf40, 8'h00, 8'h77}};

	logic              clk;
	logic              nrst;
	agc_pkg::bus_req_t bus;
	logic [7:0]        rd_data;
	agc_pkg::sample_t  sample;
	logic              sync_found;
	logic              rx_start;
	agc_pkg::gain_t    gain;
	logic              carrier_sense;
	logic              ask_bit;
	int                miscompares;
	int                checks;

	agc_gain_loop_control u_dut (
		.clk           (clk),
		.nrst          (nrst),
		.bus           (bus),
		.rd_data       (rd_data),
		.sample        (sample),
		.sync_found    (sync_found),
		.rx_start      (rx_start),
		.gain          (gain),
		.carrier_sense (carrier_sense),
		.ask_bit       (ask_bit)
	);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	// Read data stands one cycle only, then returns to zero
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd_now(a, exp);
	endtask

	// Read strobe from this edge on; a write may fill the cycle before
	task automatic rd_now(input logic [15:0] a, input logic [7:0] exp);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(rd_data, exp);
		@(posedge clk);
		#1;
		chk(rd_data, 8'h00);
	endtask

	// Write then read with no idle cycle between the strobes
	task automatic wr_rd(input row_t r);
		@(posedge clk);
		bus <= '{addr: r.addr, wdata: r.wdata, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		rd_now(r.addr, r.exp);
	endtask

	// Spaced samples so none lands in an adjust or restart cycle
	task automatic feed(input int n, input logic [7:0] db);
		repeat (n)
		begin
			@(posedge clk);
			sample <= '{valid: 1'b1, db: db};
			@(posedge clk);
			sample.valid <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic wait_cs(input logic exp);
		int i;
		for (i = 0; i < 10 && carrier_sense !== exp; i++)
			@(posedge clk);
		#1;
		chk({7'h00, carrier_sense}, {7'h00, exp});
	endtask

	task automatic close_out;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#200000;
		miscompares++;
		close_out();
	end

	initial
	begin
		miscompares = 0;
		checks = 0;
		nrst = 1'b0;
		bus = '0;
		sample = '0;
		sync_found = 1'b0;
		rx_start = 1'b0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk({2'b00, gain}, 8'h3f);
		chk({7'h00, carrier_sense}, 8'h00);
		chk({7'h00, ask_bit}, 8'h00);
		chk(rd_data, 8'h00);
		rd(16'hdf19, 8'h91);
		rd(16'hdf17, 8'h03);
		rd(16'hdf18, 8'h00);
		rd(16'hdf41, 8'h77);
		$display("test reset done");

		foreach (ROWS[k])
		begin
			wr_rd(ROWS[k]);
		end
		$display("test register rows done");

		// Window of 16: one short must leave carrier sense low
		feed(15, 8'h21);
		chk({7'h00, carrier_sense}, 8'h00);
		feed(1, 8'h21);
		wait_cs(1'b1);
		rd(16'hdf42, 8'h21);
		wr(16'hdf18, 8'h01);
		feed(16, 8'h21);
		wait_cs(1'b0);
		wr(16'hdf18, 8'h0f);
		feed(16, 8'h21);
		wait_cs(1'b1);
		wr(16'hdf18, 8'h08);
		wait_cs(1'b0);
		wr(16'hdf18, 8'h00);
		$display("test carrier sense done");

		// Window then a 16-sample settle: one step per 32, none while sync-held
		feed(32, 8'h32);
		chk({2'b00, gain}, 8'h37);
		wr(16'hdf19, 8'h99);
		feed(32, 8'h32);
		chk({2'b00, gain}, 8'h36);
		wr(16'hdf19, 8'h95);
		@(posedge clk);
		sync_found <= 1'b1;
		@(posedge clk);
		sync_found <= 1'b0;
		feed(32, 8'h32);
		chk({2'b00, gain}, 8'h36);
		@(posedge clk);
		rx_start <= 1'b1;
		@(posedge clk);
		rx_start <= 1'b0;
		feed(32, 8'h32);
		chk({2'b00, gain}, 8'h2e);
		$display("test hold modes done");

		wr(16'hdf19, 8'h9d);
		wr(16'hdf41, 8'h25);
		rd(16'hdf41, 8'h25);
		chk({2'b00, gain}, 8'h15);
		feed(32, 8'h32);
		chk({2'b00, gain}, 8'h15);
		$display("test manual gain done");

		// Margin 5 dB at averaging code 01, average 50 dB
		feed(1, 8'h2d);
		chk({7'h00, ask_bit}, 8'h01);
		feed(1, 8'h2c);
		chk({7'h00, ask_bit}, 8'h00);
		$display("test slicer done");

		// Window of 2 slicer samples and 14 weak ones averages 23 dB:
		// gain rises, and 23 + 7 steps * 3 dB meets the goal + 7 dB
		wr(16'hdf19, 8'h91);
		wr(16'hdf18, 8'h08);
		wr(16'hdf18, 8'h07);
		feed(14, 8'h14);
		chk({2'b00, gain}, 8'h1d);
		chk({7'h00, carrier_sense}, 8'h01);
		$display("test raise done");
		close_out();
	end

endmodule // agc_gain_loop_control_tb
